// file: verilog/tqcms_defines.vh
`ifndef TQCMS_DEFINES_VH
`define TQCMS_DEFINES_VH
`define TQCMS_ADDR_MONSEL 16'h0006
`define TQCMS_ADDR_POLCFG 16'h0106
`define TQCMS_ADDR_SMOOTH 16'h010e
`define TQCMS_ADDR_TSCALE 16'h0152
`define TQCMS_ADDR_MODE 16'h0200
`define TQCMS_ADDR_LIMEN 16'h0202
`define TQCMS_ADDR_MAXSPD 16'h0204
`define TQCMS_ADDR_TPRE1 16'h0206
`define TQCMS_ADDR_TPRE2 16'h0208
`define TQCMS_ADDR_TPRE3 16'h020a
`define TQCMS_ADDR_SPRE1 16'h020c
`define TQCMS_ADDR_SPRE2 16'h020e
`define TQCMS_ADDR_SPRE3 16'h0210
`define TQCMS_ADDR_PROP1 16'h0212
`define TQCMS_ADDR_PROP2 16'h0214
`define TQCMS_ADDR_STATUS 16'h0216
`define TQCMS_ADDR_TCMD 16'h0218
`define TQCMS_RST_MONSEL 16'h0001
`define TQCMS_RST_POLCFG 16'h0000
`define TQCMS_RST_SMOOTH 16'h0000
`define TQCMS_RST_TSCALE 16'h0064
`define TQCMS_RST_MODE 16'h0002
`define TQCMS_RST_LIMEN 16'h0000
`define TQCMS_RST_MAXSPD 16'h1388
`define TQCMS_RST_PROP 16'h0064
`define TQCMS_MODE_PT 8'h00
`define TQCMS_MODE_S 8'h01
`define TQCMS_MODE_T 8'h02
`define TQCMS_MODE_SZ 8'h04
`define TQCMS_MODE_TZ 8'h05
`define TQCMS_MODE_PTS 8'h06
`define TQCMS_MODE_PTT 8'h07
`define TQCMS_MODE_ST 8'h0a
`define TQCMS_LIMEN_SPD 0
`define TQCMS_LIMEN_TRQ 1
`define TQCMS_SMOOTH_MAX 16'h03e8
`define TQCMS_TSCALE_MAX 16'h03e8
`define TQCMS_MONSEL_MAX 4'h7
`define TQCMS_PROP_MAX 16'h0064
`define TQCMS_PRESET_MAX 16'sd300
`define TQCMS_SAMPLE_NS 62500
`define TQCMS_CLK_NS 4
`define TQCMS_SAMPLE_CYC (`TQCMS_SAMPLE_NS / `TQCMS_CLK_NS)
`define TQCMS_SAMPLE_MS_DIV 16
`endif

// file: verilog/tqcms_torque_mode.v
`timescale 1ns/1ns
`include "tqcms_defines.vh"
module tqcms_torque_mode #(
    parameter SAMPLE_CYC = `TQCMS_SAMPLE_CYC
) (
    // Clock and reset
    input wire ref_clk,
    input wire rstn,
    // Register port
    input wire [15:0] regAddr,
    input wire [15:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdata,
    // Pins from motion controller
    input wire servoOn,
    input wire torqueSelectLo,
    input wire torqueSelectHi,
    input wire speedSelectLo,
    input wire speedSelectHi,
    input wire modeSelect,
    // Converted analog inputs, volts times 1000, signed
    input wire signed [15:0] analogTorqueMv,
    input wire signed [15:0] analogSpeed,
    // Measured quantities for the monitors
    input wire signed [15:0] motorSpeed,
    input wire signed [15:0] motorTorque,
    input wire signed [15:0] pulseFreq,
    input wire signed [15:0] busVoltage,
    // Results
    output reg [2:0] activeMode,
    output reg signed [15:0] torqueCmd,
    output reg signed [15:0] speedCmd,
    output reg torqueLimitOn,
    output reg signed [15:0] torqueLimit,
    output reg speedLimitOn,
    output reg signed [15:0] speedLimit,
    output reg [15:0] maxSpeed,
    output reg signed [15:0] monitorChannelOne,
    output reg signed [15:0] monitorChannelTwo
);
    // One-hot active control loop
    localparam ST_POS = 3'b001;
    localparam ST_SPD = 3'b010;
    localparam ST_TRQ = 3'b100;

    reg [15:0] monSelFf, polCfgFf, smoothFf, tScaleFf, modeFf, limEnFf;
    reg [15:0] maxSpdFf, prop1Ff, prop2Ff;
    reg signed [15:0] tPre1Ff, tPre2Ff, tPre3Ff;
    reg signed [15:0] sPre1Ff, sPre2Ff, sPre3Ff;
    reg [5:0] syncAFf, syncBFf;
    reg [1:0] tSelPrevFf;
    reg presetValidFf;
    reg [15:0] sampleCntFf;
    reg signed [31:0] filtFf;
    reg signed [15:0] tSrc, sSrc, scaled;
    reg [2:0] nxtMode;
    reg [3:0] ch1Code, ch2Code;
    reg signed [31:0] wideT, filtNext;
    wire sOn = syncBFf[0];
    wire [1:0] tSel = syncBFf[2:1];
    wire [1:0] sSel = syncBFf[4:3];
    wire modeIn = syncBFf[5];
    wire sampleTick = (sampleCntFf == 16'h0000);

    // Two flops before any logic sees the pins
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            syncAFf <= 6'h00;
            syncBFf <= 6'h00;
        end else begin
            syncAFf <= {modeSelect, speedSelectHi, speedSelectLo,
                        torqueSelectHi, torqueSelectLo, servoOn};
            syncBFf <= syncAFf;
        end
    end

    // Register writes; out-of-range writes are dropped, torque presets clamped
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            monSelFf <= `TQCMS_RST_MONSEL;
            polCfgFf <= `TQCMS_RST_POLCFG;
            smoothFf <= `TQCMS_RST_SMOOTH;
            tScaleFf <= `TQCMS_RST_TSCALE;
            modeFf <= `TQCMS_RST_MODE;
            limEnFf <= `TQCMS_RST_LIMEN;
            maxSpdFf <= `TQCMS_RST_MAXSPD;
            prop1Ff <= `TQCMS_RST_PROP;
            prop2Ff <= `TQCMS_RST_PROP;
            tPre1Ff <= 16'sh0000;
            tPre2Ff <= 16'sh0000;
            tPre3Ff <= 16'sh0000;
            sPre1Ff <= 16'sh0000;
            sPre2Ff <= 16'sh0000;
            sPre3Ff <= 16'sh0000;
        end else if (regWr) begin
            case (regAddr)
                `TQCMS_ADDR_MONSEL: begin
                    // Digits above 7 are out of range and ignored
                    if (regWdata[7:4] <= `TQCMS_MONSEL_MAX &&
                        regWdata[3:0] <= `TQCMS_MONSEL_MAX)
                        monSelFf <= {8'h00, regWdata[7:0]};
                end
                `TQCMS_ADDR_POLCFG: polCfgFf <= regWdata;
                `TQCMS_ADDR_SMOOTH: begin
                    if (regWdata <= `TQCMS_SMOOTH_MAX)
                        smoothFf <= regWdata;
                end
                `TQCMS_ADDR_TSCALE: begin
                    if (regWdata <= `TQCMS_TSCALE_MAX)
                        tScaleFf <= regWdata;
                end
                `TQCMS_ADDR_MODE: modeFf <= regWdata;
                `TQCMS_ADDR_LIMEN: limEnFf <= regWdata;
                `TQCMS_ADDR_MAXSPD: maxSpdFf <= regWdata;
                `TQCMS_ADDR_TPRE1: tPre1Ff <= clampPre(regWdata);
                `TQCMS_ADDR_TPRE2: tPre2Ff <= clampPre(regWdata);
                `TQCMS_ADDR_TPRE3: tPre3Ff <= clampPre(regWdata);
                `TQCMS_ADDR_SPRE1: sPre1Ff <= regWdata;
                `TQCMS_ADDR_SPRE2: sPre2Ff <= regWdata;
                `TQCMS_ADDR_SPRE3: sPre3Ff <= regWdata;
                `TQCMS_ADDR_PROP1: begin
                    if (regWdata <= `TQCMS_PROP_MAX)
                        prop1Ff <= regWdata;
                end
                `TQCMS_ADDR_PROP2: begin
                    if (regWdata <= `TQCMS_PROP_MAX)
                        prop2Ff <= regWdata;
                end
                default: ;
            endcase
        end
    end

    function signed [15:0] clampPre;
        input [15:0] v;
        begin
            if ($signed(v) > `TQCMS_PRESET_MAX)
                clampPre = `TQCMS_PRESET_MAX;
            else if ($signed(v) < -`TQCMS_PRESET_MAX)
                clampPre = -`TQCMS_PRESET_MAX;
            else
                clampPre = v;
        end
    endfunction

    // Read data one cycle after the strobe; unmapped reads give zero
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `TQCMS_ADDR_MONSEL: regRdata <= monSelFf;
                `TQCMS_ADDR_POLCFG: regRdata <= polCfgFf;
                `TQCMS_ADDR_SMOOTH: regRdata <= smoothFf;
                `TQCMS_ADDR_TSCALE: regRdata <= tScaleFf;
                `TQCMS_ADDR_MODE: regRdata <= modeFf;
                `TQCMS_ADDR_LIMEN: regRdata <= limEnFf;
                `TQCMS_ADDR_MAXSPD: regRdata <= maxSpdFf;
                `TQCMS_ADDR_TPRE1: regRdata <= tPre1Ff;
                `TQCMS_ADDR_TPRE2: regRdata <= tPre2Ff;
                `TQCMS_ADDR_TPRE3: regRdata <= tPre3Ff;
                `TQCMS_ADDR_SPRE1: regRdata <= sPre1Ff;
                `TQCMS_ADDR_SPRE2: regRdata <= sPre2Ff;
                `TQCMS_ADDR_SPRE3: regRdata <= sPre3Ff;
                `TQCMS_ADDR_PROP1: regRdata <= prop1Ff;
                `TQCMS_ADDR_PROP2: regRdata <= prop2Ff;
                `TQCMS_ADDR_STATUS:
                    regRdata <= {9'h000, presetValidFf, activeMode,
                                 torqueLimitOn, speedLimitOn, sOn};
                `TQCMS_ADDR_TCMD: regRdata <= torqueCmd;
                default: regRdata <= 16'h0000;
            endcase
        end
    end

    // Pick the active loop from the mode code and select input
    always @* begin
        case (modeFf[7:0])
            `TQCMS_MODE_PT: nxtMode = ST_POS;
            `TQCMS_MODE_S, `TQCMS_MODE_SZ: nxtMode = ST_SPD;
            `TQCMS_MODE_T, `TQCMS_MODE_TZ: nxtMode = ST_TRQ;
            `TQCMS_MODE_PTS: nxtMode = modeIn ? ST_POS : ST_SPD;
            `TQCMS_MODE_PTT: nxtMode = modeIn ? ST_POS : ST_TRQ;
            `TQCMS_MODE_ST: nxtMode = modeIn ? ST_TRQ : ST_SPD;
            default: nxtMode = ST_POS;
        endcase
    end

    // Preset turns valid once the torque selector changes to a nonzero code
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tSelPrevFf <= 2'b00;
            presetValidFf <= 1'b0;
        end else begin
            tSelPrevFf <= tSel;
            if (tSel == 2'b00 || !sOn)
                presetValidFf <= 1'b0;
            else if (tSel != tSelPrevFf)
                presetValidFf <= 1'b1;
        end
    end

    // Source selection; dual codes never take the zero-ref path
    always @* begin
        scaled = 16'sh0000;
        wideT = analogTorqueMv * $signed({1'b0, tScaleFf});
        // Percent = volts * scale / 10
        wideT = wideT / 32'sd10000;
        scaled = wideT[15:0];
        tSrc = 16'sh0000;
        if (!sOn)
            tSrc = 16'sh0000;
        else begin
            case (tSel)
                2'b00: tSrc = (modeFf[7:0] == `TQCMS_MODE_TZ) ?
                              16'sh0000 : scaled;
                2'b01: tSrc = presetValidFf ? tPre1Ff : 16'sh0000;
                2'b10: tSrc = presetValidFf ? tPre2Ff : 16'sh0000;
                2'b11: tSrc = presetValidFf ? tPre3Ff : 16'sh0000;
                default: tSrc = 16'sh0000;
            endcase
        end
        case (sSel)
            2'b00: sSrc = (modeFf[7:0] == `TQCMS_MODE_SZ) ?
                          16'sh0000 : analogSpeed;
            2'b01: sSrc = sPre1Ff;
            2'b10: sSrc = sPre2Ff;
            2'b11: sSrc = sPre3Ff;
            default: sSrc = 16'sh0000;
        endcase
        // Divider-based filter: alpha = 1 / (1 + ms * 2), stepped once per sample tick
        // needs a full divider; a smoothing of zero passes tSrc straight through
        filtNext = filtFf + ((($signed({tSrc, 16'h0000}) - filtFf)) /
                   $signed({15'h0000, smoothFf, 1'b1}));
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sampleCntFf <= 16'h0000;
            filtFf <= 32'sh00000000;
        end else begin
            sampleCntFf <= sampleTick ? SAMPLE_CYC[15:0] - 16'h0001 :
                           sampleCntFf - 16'h0001;
            if (smoothFf == 16'h0000)
                filtFf <= {tSrc, 16'h0000};
            else if (sampleTick)
                filtFf <= filtNext;
        end
    end

    function signed [15:0] monPick;
        input [3:0] code;
        begin
            case (code)
                4'h0: monPick = motorSpeed;
                4'h1: monPick = motorTorque;
                4'h2: monPick = pulseFreq;
                4'h3: monPick = speedCmd;
                4'h4: monPick = torqueCmd;
                4'h5: monPick = busVoltage;
                default: monPick = 16'sh0000;
            endcase
        end
    endfunction

    function signed [15:0] monScale;
        input signed [15:0] v;
        input [15:0] prop;
        reg signed [31:0] w;
        begin
            // Channel output = value * 100 / proportion
            if (prop == 16'h0000)
                monScale = 16'sh0000;
            else begin
                w = (v * 32'sd100) / $signed({16'h0000, prop});
                monScale = w[15:0];
            end
        end
    endfunction

    always @* begin
        ch1Code = monSelFf[7:4];
        ch2Code = monSelFf[3:0];
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            activeMode <= ST_POS;
            torqueCmd <= 16'sh0000;
            speedCmd <= 16'sh0000;
            torqueLimitOn <= 1'b0;
            torqueLimit <= 16'sh0000;
            speedLimitOn <= 1'b0;
            speedLimit <= 16'sh0000;
            maxSpeed <= 16'h0000;
            monitorChannelOne <= 16'sh0000;
            monitorChannelTwo <= 16'sh0000;
        end else begin
            activeMode <= nxtMode;
            torqueCmd <= (nxtMode == ST_TRQ) ? filtFf[31:16] : 16'sh0000;
            speedCmd <= (nxtMode == ST_SPD) ? sSrc : 16'sh0000;
            maxSpeed <= maxSpdFf;
            speedLimitOn <= (nxtMode == ST_TRQ) &&
                            limEnFf[`TQCMS_LIMEN_SPD];
            speedLimit <= sSrc;
            torqueLimitOn <= (nxtMode != ST_TRQ) &&
                             limEnFf[`TQCMS_LIMEN_TRQ];
            torqueLimit <= tSrc;
            // Polarity digit bit 1 inverts channel one, bit 0 two
            monitorChannelOne <= polCfgFf[1] ?
                -monScale(monPick(ch1Code), prop1Ff) :
                monScale(monPick(ch1Code), prop1Ff);
            monitorChannelTwo <= polCfgFf[0] ?
                -monScale(monPick(ch2Code), prop2Ff) :
                monScale(monPick(ch2Code), prop2Ff);
        end
    end
endmodule

// file: verif/tqcms_checker.sv
`timescale 1ns/1ns
module tqcms_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    // Pins and results
    input wire logic servoOn,
    input wire logic [2:0] activeMode,
    input wire logic signed [15:0] torqueCmd,
    input wire logic signed [15:0] speedCmd,
    input wire logic torqueLimitOn,
    input wire logic speedLimitOn,
    input wire logic [15:0] maxSpeed
);
    logic [2:0] upCnt_ff;
    // Masks the load of register values in the first edges after reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            upCnt_ff <= 3'h0;
        else if (upCnt_ff != 3'h7)
            upCnt_ff <= upCnt_ff + 3'h1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // Five edges cover the two-flop sync, the filter register at a smoothing of zero and the output register
    sequence servoOffHeld;
        !servoOn [*5];
    endsequence
    sequence busQuiet;
        !regWr ##1 !regWr;
    endsequence
    AST_ONE_HOT: assert property ($onehot(activeMode))
        else $error("active mode not one-hot");
    AST_SERVO_OFF: assert property (
        servoOffHeld |-> torqueCmd == 16'sh0000)
        else $error("torque command while servo off");
    AST_TLIM_MODE: assert property (
        torqueLimitOn |-> !activeMode[2])
        else $error("torque limit in torque mode");
    AST_SLIM_MODE: assert property (
        speedLimitOn |-> activeMode[2])
        else $error("speed limit outside torque mode");
    AST_TCMD_MODE: assert property (
        torqueCmd != 16'sh0000 |-> activeMode == 3'h4)
        else $error("torque command outside torque mode");
    AST_SCMD_MODE: assert property (
        speedCmd != 16'sh0000 |-> activeMode == 3'h2)
        else $error("speed command outside speed mode");
    AST_RDATA_HOLD: assert property (
        upCnt_ff == 3'h7 && !$past(regRd) |-> $stable(regRdata))
        else $error("read data moved without a read");
    AST_MAXSPD_HOLD: assert property (
        busQuiet ##1 upCnt_ff == 3'h7 |-> $stable(maxSpeed))
        else $error("max speed moved without a write");
endmodule

bind tqcms_torque_mode tqcms_checker chk (
    .ref_clk(ref_clk), .rstn(rstn), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .servoOn(servoOn), .activeMode(activeMode),
    .torqueCmd(torqueCmd), .speedCmd(speedCmd),
    .torqueLimitOn(torqueLimitOn), .speedLimitOn(speedLimitOn),
    .maxSpeed(maxSpeed));

// file: verif/tqcms_partner.sv
`timescale 1ns/1ns
module tqcms_partner (
    // Clock
    input wire logic ref_clk,
    // Requests from the bench
    input wire logic [5:0] pinReq,
    input wire logic signed [15:0] mvReq,
    // Controller outputs
    output logic servoOn,
    output logic torqueSelectLo,
    output logic torqueSelectHi,
    output logic speedSelectLo,
    output logic speedSelectHi,
    output logic modeSelect,
    output logic signed [15:0] analogTorqueMv
);
    initial begin
        {modeSelect, speedSelectHi, speedSelectLo} = 3'h0;
        {torqueSelectHi, torqueSelectLo, servoOn} = 3'h0;
        analogTorqueMv = 16'sh0000;
    end
    // Levels move together, so selector codes never pass a false code
    always @(posedge ref_clk) begin
        {modeSelect, speedSelectHi, speedSelectLo} <= pinReq[5:3];
        {torqueSelectHi, torqueSelectLo, servoOn} <= pinReq[2:0];
        analogTorqueMv <= mvReq;
    end
endmodule

// file: verif/tqcms_torque_mode_tb.sv
`timescale 1ns/1ns
`include "tqcms_defines.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module tqcms_torque_mode_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic rdSeen = 1'b0;
    logic [5:0] pinReq = 6'h00;
    logic signed [15:0] mvReq = 16'sh0000;
    logic signed [15:0] src [0:5] = '{6{16'sh0100}};
    logic [31:0] seed = 32'h00000046;
    logic [15:0] expQ [$];
    logic [7:0] dualCode [0:2] = '{8'h06, 8'h07, 8'h0a};
    logic [2:0] dualExp [0:5] = '{3'h1, 3'h2, 3'h1, 3'h4, 3'h4, 3'h2};
    int err_count = 0;
    int compares = 0;
    int i, v, sc, mv;
    wire servoOn, tsLo, tsHi, ssLo, ssHi, modeSel, tLimOn, sLimOn;
    wire signed [15:0] tMv, torqueCmd, tLim, monitor_channel_one, monitor_channel_two, sCmd, sLim;
    wire [15:0] regRdata, maxSpd;
    wire [2:0] activeMode;

    always #2 ref_clk = ~ref_clk;

    tqcms_partner ctl (.ref_clk(ref_clk), .pinReq(pinReq), .mvReq(mvReq),
        .servoOn(servoOn), .torqueSelectLo(tsLo), .torqueSelectHi(tsHi),
        .speedSelectLo(ssLo), .speedSelectHi(ssHi), .modeSelect(modeSel),
        .analogTorqueMv(tMv));
    tqcms_torque_mode #(.SAMPLE_CYC(4)) dut (.ref_clk(ref_clk), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .servoOn(servoOn), .torqueSelectLo(tsLo),
        .torqueSelectHi(tsHi), .speedSelectLo(ssLo), .speedSelectHi(ssHi),
        .modeSelect(modeSel), .analogTorqueMv(tMv), .analogSpeed(src[3]),
        .motorSpeed(src[0]), .motorTorque(src[1]), .pulseFreq(src[2]),
        .busVoltage(src[5]), .activeMode(activeMode), .torqueCmd(torqueCmd),
        .speedCmd(sCmd), .torqueLimitOn(tLimOn), .torqueLimit(tLim),
        .speedLimitOn(sLimOn), .speedLimit(sLim), .maxSpeed(maxSpd),
        .monitorChannelOne(monitor_channel_one), .monitorChannelTwo(monitor_channel_two));

    // Read data appear in the cycle after the strobe and hold until the next read
    always @(posedge ref_clk) begin
        if (rdSeen)
            `CHK(regRdata, expQ.pop_front())
        rdSeen <= regRd;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] pick(input int s);
        case (s)
            0: return torqueCmd;
            1: return {13'h0000, activeMode};
            2: return monitor_channel_one;
            3: return monitor_channel_two;
            4: return {14'h0000, tLimOn, sLimOn};
            5: return tLim;
            6: return sCmd;
            7: return maxSpd;
            default: return sLim;
        endcase
    endfunction
    task automatic conclude;
        $display("Compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] x);
        @(posedge ref_clk);
        expQ.push_back(x);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask
    // Pins pass a sync chain, so results are awaited under a bound
    task automatic settle(input int s, input logic [15:0] x);
        int n;
        // Wait out partner, sync chain and filter flop; the first look comes before
        // the output flop's update on the fifth edge, so a stale match can still pass
        repeat (5) @(posedge ref_clk);
        for (n = 0; n < 60 && pick(s) !== x; n++)
            @(posedge ref_clk) #1;
        if (n == 60) begin
            err_count++;
            conclude();
        end
        `CHK(pick(s), x)
        @(posedge ref_clk);
    endtask

    initial begin
        #200000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(`TQCMS_ADDR_MONSEL, 16'h0001);
        rd(`TQCMS_ADDR_POLCFG, 16'h0000);
        rd(`TQCMS_ADDR_TSCALE, 16'h0064);
        rd(16'h0300, 16'h0000);
        settle(7, 16'h1388);
        wr(`TQCMS_ADDR_SMOOTH, 16'h03e9);
        wr(`TQCMS_ADDR_MONSEL, 16'h0078);
        wr(`TQCMS_ADDR_TSCALE, 16'h03e9);
        rd(`TQCMS_ADDR_SMOOTH, 16'h0000);
        rd(`TQCMS_ADDR_MONSEL, 16'h0001);
        rd(`TQCMS_ADDR_TSCALE, 16'h0064);
        pinReq <= 6'h01;
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            sc = (i == 0) ? 1000 : seed[31:16] % 1001;
            mv = $signed(seed[15:0]) % 10001;
            wr(`TQCMS_ADDR_TSCALE, sc[15:0]);
            mvReq <= mv[15:0];
            settle(0, 16'(mv * sc / 10000));
        end
        wr(`TQCMS_ADDR_MODE, 16'h0005);
        settle(0, 16'h0000);
        wr(`TQCMS_ADDR_MODE, 16'h0002);
        wr(`TQCMS_ADDR_TPRE2, 16'h0190);
        rd(`TQCMS_ADDR_TPRE2, 16'h012c);
        wr(`TQCMS_ADDR_TPRE3, 16'hff38);
        pinReq <= 6'h03;
        repeat (8) @(posedge ref_clk);
        pinReq <= 6'h07;
        settle(0, 16'hff38);
        pinReq <= 6'h05;
        settle(0, 16'h012c);
        pinReq <= 6'h04;
        settle(0, 16'h0000);
        pinReq <= 6'h01;
        mvReq <= 16'sh0000;
        wr(`TQCMS_ADDR_TSCALE, 16'h0064);
        wr(`TQCMS_ADDR_SMOOTH, 16'h000a);
        mvReq <= 16'sh2710;
        repeat (6) @(posedge ref_clk);
        `CHK(torqueCmd !== 16'sh0064, 1'b1)
        wr(`TQCMS_ADDR_SMOOTH, 16'h0000);
        settle(0, 16'h0064);
        for (i = 0; i < 6; i++) begin
            wr(`TQCMS_ADDR_MODE, {8'h00, dualCode[i / 2]});
            pinReq <= {!i[0], 5'h01};
            settle(1, {13'h0000, dualExp[i]});
        end
        settle(6, 16'h0100);
        wr(`TQCMS_ADDR_MODE, 16'h0000);
        wr(`TQCMS_ADDR_LIMEN, 16'h0003);
        settle(4, 16'h0002);
        settle(5, 16'h0064);
        wr(`TQCMS_ADDR_MODE, 16'h0002);
        settle(4, 16'h0001);
        settle(8, 16'h0100);
        wr(`TQCMS_ADDR_LIMEN, 16'h0000);
        settle(4, 16'h0000);
        pinReq <= 6'h00;
        wr(`TQCMS_ADDR_PROP2, 16'h0032);
        for (i = 0; i < 6; i++) begin
            seed = xs(seed);
            v = $signed(seed[10:0]);
            src[i] <= 16'(v);
            if (i == 3 || i == 4)
                v = 0;
            wr(`TQCMS_ADDR_POLCFG, 16'(i % 4));
            wr(`TQCMS_ADDR_MONSEL, {8'h00, i[3:0], i[3:0]});
            settle(2, 16'(i[1] ? -v : v));
            settle(3, 16'(i[0] ? -2 * v : 2 * v));
        end
        repeat (3) @(posedge ref_clk);
        conclude();
    end
endmodule
